//--- hw/dtc_timer_counter.sv
// Dual timer/counter with run/flag and mode registers
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_timer_counter (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Special function register port
  input  wire logic              sfrWrEn,
  input  wire logic              sfrRdEn,
  input  wire dtc_pkg::dtc_sfr_t sfrSel,
  input  wire logic [7:0]        sfrWrData,
  output logic      [7:0]        sfrRdData,
  // Interrupt vector acknowledges
  input  wire logic              vecAckOvfA,
  input  wire logic              vecAckOvfB,
  input  wire logic              vecAckIrqA,
  input  wire logic              vecAckIrqB,
  // External pins
  input  wire logic              count_pin_a,
  input  wire logic              count_pin_b,
  input  wire logic              ext_irq_pin_a,
  input  wire logic              ext_irq_pin_b,
  // Interrupt requests
  output logic                   overflowFlagA,
  output logic                   overflowFlagB,
  output logic                   irqEdgeFlagA,
  output logic                   irqEdgeFlagB
);

  // ****************************************************************
  // Count step
  // ****************************************************************
  // Returns {overflow, high, low} after one count in the given mode
  function automatic logic [16:0] stepCount(dtc_pkg::dtc_mode_t md,
                                            logic [7:0] lo,
                                            logic [7:0] hi);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    case (md)
      dtc_pkg::DTC_M13: begin
        res[16] = (hi == `DTC_BYTE_ONES) &&
                  (lo[`DTC_PRESCALE_MSB:0] == `DTC_PRESCALE_ONES);
        {res[15:8], res[`DTC_PRESCALE_MSB:0]} =
          13'({hi, lo[`DTC_PRESCALE_MSB:0]} + 13'h1);
      end
      dtc_pkg::DTC_M16: begin
        {res[16], res[15:0]} = 17'({hi, lo} + 16'h1);
      end
      dtc_pkg::DTC_M8RELOAD: begin
        res[16]  = (lo == `DTC_BYTE_ONES);
        res[7:0] = res[16] ? hi : 8'(lo + 8'h1);
      end
      default: begin
        res[16]  = (lo == `DTC_BYTE_ONES);
        res[7:0] = 8'(lo + 8'h1);
      end
    endcase
    return res;
  endfunction : stepCount

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
    end else begin
      pinMeta_r <= {ext_irq_pin_b, ext_irq_pin_a, count_pin_b, count_pin_a};
      pinSync_r <= pinMeta_r;
    end
  end

  // ****************************************************************
  // Machine cycle phase and pin sampling
  // ****************************************************************
  logic [`DTC_PHASE_W-1:0] phase_r, phase_nxt;
  logic [3:0]              pinSmp_r, pinSmp_nxt;
  logic [1:0]              cntPend_r, cntPend_nxt;
  logic                    updTick;
  logic                    smpTick;
  logic [3:0]              pinFall;

  assign updTick = (phase_r == `DTC_UPDATE_PHASE);
  assign smpTick = (phase_r == `DTC_SAMPLE_PHASE);
  // Falling edge between two successive machine-cycle samples
  assign pinFall = pinSmp_r & ~pinSync_r;

  always_comb begin
    phase_nxt   = (phase_r == `DTC_PHASE_LAST) ? '0 :
                  `DTC_PHASE_W'(phase_r + 1'b1);
    pinSmp_nxt  = smpTick ? pinSync_r : pinSmp_r;
    cntPend_nxt = cntPend_r;
    // A detected edge waits for the next cycle's update phase, so
    // recognition spans two machine cycles
    if (updTick)
      cntPend_nxt = 2'b00;
    if (smpTick)
      cntPend_nxt = cntPend_nxt | pinFall[1:0];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_r   <= '0;
      pinSmp_r  <= 4'hf;
      cntPend_r <= 2'b00;
    end else begin
      phase_r   <= phase_nxt;
      pinSmp_r  <= pinSmp_nxt;
      cntPend_r <= cntPend_nxt;
    end
  end

  // ****************************************************************
  // Registers and counting
  // ****************************************************************
  logic [7:0] runFlags_r, runFlags_nxt;
  logic [7:0] modeSel_r, modeSel_nxt;
  logic [7:0] lowA_r, lowA_nxt, highA_r, highA_nxt;
  logic [7:0] lowB_r, lowB_nxt, highB_r, highB_nxt;
  logic [7:0] rdData_r, rdData_nxt;

  dtc_pkg::dtc_mode_t modeA, modeB;
  logic        splitA;
  logic        enA, enB, enHighA;
  logic        evA, evB;
  logic [16:0] stepA, stepB;
  logic        setOvfA, setOvfB, setIrqA, setIrqB;
  logic        wrRun, wrMode;

  assign modeA  = dtc_pkg::dtc_mode_t'(modeSel_r[`DTC_MD_MODE_A]);
  assign modeB  = dtc_pkg::dtc_mode_t'(modeSel_r[`DTC_MD_MODE_B]);
  assign splitA = (modeA == dtc_pkg::DTC_M3);

  // Each select bit picks machine cycles or counted pin edges
  assign evA = modeSel_r[`DTC_MD_CT_A] ? cntPend_r[0] : 1'b1;
  assign evB = modeSel_r[`DTC_MD_CT_B] ? cntPend_r[1] : 1'b1;

  // Run bit with gate; gate high lets the irq pin time a pulse
  assign enA = runFlags_r[`DTC_TC_RUN_A] &&
               (!modeSel_r[`DTC_MD_GATE_A] || pinSync_r[2]);
  // While A is split, B loses its run bit and is switched by mode 3
  assign enB = (splitA || runFlags_r[`DTC_TC_RUN_B]) &&
               (!modeSel_r[`DTC_MD_GATE_B] || pinSync_r[3]) &&
               (modeB != dtc_pkg::DTC_M3);
  assign enHighA = splitA && runFlags_r[`DTC_TC_RUN_B];

  assign stepA = stepCount(modeA, lowA_r, highA_r);
  assign stepB = stepCount(modeB, lowB_r, highB_r);

  assign setOvfA = updTick && enA && evA && stepA[16];
  // Split high byte of A owns B's overflow flag
  assign setOvfB = splitA ?
                   (updTick && enHighA && highA_r == `DTC_BYTE_ONES) :
                   (updTick && enB && evB && stepB[16]);

  // Edge type sets on a fall, level type while the pin is low
  assign setIrqA = smpTick && (runFlags_r[`DTC_TC_TYPE_A] ?
                   pinFall[2] : !pinSync_r[2]);
  assign setIrqB = smpTick && (runFlags_r[`DTC_TC_TYPE_B] ?
                   pinFall[3] : !pinSync_r[3]);

  assign wrRun  = sfrWrEn && (sfrSel == dtc_pkg::DTC_SEL_RUNFLAGS);
  assign wrMode = sfrWrEn && (sfrSel == dtc_pkg::DTC_SEL_MODE);

  always_comb begin
    runFlags_nxt = runFlags_r;
    modeSel_nxt  = wrMode ? sfrWrData : modeSel_r;
    lowA_nxt     = lowA_r;
    highA_nxt    = highA_r;
    lowB_nxt     = lowB_r;
    highB_nxt    = highB_r;
    rdData_nxt   = rdData_r;

    // Vectoring clears flags; software may write any bit
    if (vecAckOvfB)
      runFlags_nxt[`DTC_TC_OVF_B] = 1'b0;
    if (vecAckOvfA)
      runFlags_nxt[`DTC_TC_OVF_A] = 1'b0;
    if (vecAckIrqB)
      runFlags_nxt[`DTC_TC_IRQF_B] = 1'b0;
    if (vecAckIrqA)
      runFlags_nxt[`DTC_TC_IRQF_A] = 1'b0;
    if (wrRun)
      runFlags_nxt = sfrWrData;
    // Hardware set wins over any clear in the same cycle
    runFlags_nxt[`DTC_TC_OVF_B]  = runFlags_nxt[`DTC_TC_OVF_B]  | setOvfB;
    runFlags_nxt[`DTC_TC_OVF_A]  = runFlags_nxt[`DTC_TC_OVF_A]  | setOvfA;
    runFlags_nxt[`DTC_TC_IRQF_B] = runFlags_nxt[`DTC_TC_IRQF_B] | setIrqB;
    runFlags_nxt[`DTC_TC_IRQF_A] = runFlags_nxt[`DTC_TC_IRQF_A] | setIrqA;

    // Counting; the run bit never clears the count
    if (updTick && enA && evA) begin
      lowA_nxt = stepA[7:0];
      if (!splitA)
        highA_nxt = stepA[15:8];
    end
    if (updTick && enHighA)
      highA_nxt = 8'(highA_r + 8'h1);
    if (updTick && enB && evB) begin
      lowB_nxt  = stepB[7:0];
      highB_nxt = stepB[15:8];
    end

    // A software write takes priority over a count in the same cycle
    if (sfrWrEn) begin
      case (sfrSel)
        dtc_pkg::DTC_SEL_LOW_A:  lowA_nxt  = sfrWrData;
        dtc_pkg::DTC_SEL_HIGH_A: highA_nxt = sfrWrData;
        dtc_pkg::DTC_SEL_LOW_B:  lowB_nxt  = sfrWrData;
        dtc_pkg::DTC_SEL_HIGH_B: highB_nxt = sfrWrData;
        default: begin
        end
      endcase
    end

    if (sfrRdEn) begin
      case (sfrSel)
        dtc_pkg::DTC_SEL_RUNFLAGS: rdData_nxt = runFlags_r;
        dtc_pkg::DTC_SEL_MODE:     rdData_nxt = modeSel_r;
        dtc_pkg::DTC_SEL_LOW_A:    rdData_nxt = lowA_r;
        dtc_pkg::DTC_SEL_HIGH_A:   rdData_nxt = highA_r;
        dtc_pkg::DTC_SEL_LOW_B:    rdData_nxt = lowB_r;
        dtc_pkg::DTC_SEL_HIGH_B:   rdData_nxt = highB_r;
        default:                   rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      runFlags_r <= `DTC_RST_BYTE;
      modeSel_r  <= `DTC_RST_BYTE;
      lowA_r     <= `DTC_RST_BYTE;
      highA_r    <= `DTC_RST_BYTE;
      lowB_r     <= `DTC_RST_BYTE;
      highB_r    <= `DTC_RST_BYTE;
      rdData_r   <= `DTC_RST_BYTE;
    end else begin
      runFlags_r <= runFlags_nxt;
      modeSel_r  <= modeSel_nxt;
      lowA_r     <= lowA_nxt;
      highA_r    <= highA_nxt;
      lowB_r     <= lowB_nxt;
      highB_r    <= highB_nxt;
      rdData_r   <= rdData_nxt;
    end
  end

  assign sfrRdData     = rdData_r;
  assign overflowFlagA = runFlags_r[`DTC_TC_OVF_A];
  assign overflowFlagB = runFlags_r[`DTC_TC_OVF_B];
  assign irqEdgeFlagA  = runFlags_r[`DTC_TC_IRQF_A];
  assign irqEdgeFlagB  = runFlags_r[`DTC_TC_IRQF_B];

endmodule : dtc_timer_counter
`default_nettype wire

//--- inc/dtc_consts.svh
// Constants for the dual timer/counter block
// Function
// - Timer function counts one per machine cycle
// - Counter samples pin, counts on high-then-low
// - Counted edge appears in following machine cycle
// - Edge recognition takes two machine cycles
// - Per-timer select: machine cycles or pin edges
// - Two-bit mode field, four modes per timer
// - Overflow flags set on overflow, cleared on vector
// - Run bits written by software start/stop timers
// - Interrupt edge flags set by hardware, cleared processed
// - Type bits pick falling-edge or low-level interrupt
// - Mode 0: 13 bits, high byte over five
// - Mode 0: eight-bit counter after divide-by-32
// - Mode 0 rollover sets overflow flag
// - Count enabled by run and gate or pin
// - Setting run bit keeps count value
// - Both timers share mode 0, separate gates
// - Modes: 13-bit, 16-bit, reload, stop/split
// - Mode 2 low overflow reloads from high byte
// - Mode 3 splits timer A, high uses B's bits
// - Timer B in mode 3 holds its count
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// ****************************************************************
// Machine cycle
// ****************************************************************
`define DTC_OSC_PER_MC     4'hc
`define DTC_PHASE_W        4
`define DTC_PHASE_LAST     4'hb
`define DTC_UPDATE_PHASE   4'h2
`define DTC_SAMPLE_PHASE   4'h9

// ****************************************************************
// Control/flag register bits
// ****************************************************************
`define DTC_TC_OVF_B       7
`define DTC_TC_RUN_B       6
`define DTC_TC_OVF_A       5
`define DTC_TC_RUN_A       4
`define DTC_TC_IRQF_B      3
`define DTC_TC_TYPE_B      2
`define DTC_TC_IRQF_A      1
`define DTC_TC_TYPE_A      0

// ****************************************************************
// Mode register fields (timer A low nibble, timer B high nibble)
// ****************************************************************
`define DTC_MD_GATE_A      3
`define DTC_MD_CT_A        2
`define DTC_MD_MODE_A      1:0
`define DTC_MD_GATE_B      7
`define DTC_MD_CT_B        6
`define DTC_MD_MODE_B      5:4

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define DTC_PRESCALE_MSB   4
`define DTC_BYTE_ONES      8'hff
`define DTC_PRESCALE_ONES  5'h1f
`define DTC_RST_BYTE       8'h00

`endif

//--- inc/dtc_pkg.sv
// Types shared by the dual timer/counter block
package dtc_pkg;

  // Operating mode, in mode-field order
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8RELOAD,
    DTC_M3
  } dtc_mode_t;

  // Special function register select
  typedef enum logic [2:0] {
    DTC_SEL_RUNFLAGS,
    DTC_SEL_MODE,
    DTC_SEL_LOW_A,
    DTC_SEL_HIGH_A,
    DTC_SEL_LOW_B,
    DTC_SEL_HIGH_B
  } dtc_sfr_t;

endpackage : dtc_pkg

//--- verif/dtc_tc_assertions.sv
// Port-level checker for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module dtc_tc_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Register port
  input wire logic       sfrWrEn,
  input wire logic       sfrRdEn,
  input wire dtc_pkg::dtc_sfr_t sfrSel,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // Acknowledges and pin
  input wire logic       vecAckOvfA,
  input wire logic       vecAckOvfB,
  input wire logic       vecAckIrqA,
  input wire logic       ext_irq_pin_a,
  // Flags
  input wire logic       overflowFlagA,
  input wire logic       overflowFlagB,
  input wire logic       irqEdgeFlagA
);
  logic       wrFlags;
  logic [5:0] lowAge_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign wrFlags = sfrWrEn && sfrSel == dtc_pkg::DTC_SEL_RUNFLAGS;
  // Age of the last low pin level; bounds how late an irq flag may rise
  always_ff @(posedge clk) begin
    if (!reset_n || !ext_irq_pin_a) lowAge_r <= 6'h00;
    else if (lowAge_r != 6'h3f) lowAge_r <= lowAge_r + 6'h01;
  end
  sequence s_wr_rd(dtc_pkg::dtc_sfr_t s);
    sfrWrEn && sfrSel == s ##1 !sfrWrEn ##1 sfrRdEn && sfrSel == s;
  endsequence
  a_mode_readback: assert property (s_wr_rd(dtc_pkg::DTC_SEL_MODE)
    |=> sfrRdData == $past(sfrWrData, 3)) else $error("mode read bad");
  a_run_readback: assert property (s_wr_rd(dtc_pkg::DTC_SEL_RUNFLAGS)
    |=> (sfrRdData & 8'h55) == ($past(sfrWrData, 3) & 8'h55))
    else $error("run or type bits read bad");
  a_unmapped_zero: assert property (sfrRdEn && sfrSel[2:1] == 2'h3
    |=> sfrRdData == 8'h00) else $error("unmapped read not zero");
  a_ovfa_clear_cause: assert property ($fell(overflowFlagA)
    |-> $past(vecAckOvfA) || $past(wrFlags)) else $error("ovf a fell");
  a_ovfb_clear_cause: assert property ($fell(overflowFlagB)
    |-> $past(vecAckOvfB) || $past(wrFlags)) else $error("ovf b fell");
  a_irq_clear_cause: assert property ($fell(irqEdgeFlagA)
    |-> $past(vecAckIrqA) || $past(wrFlags)) else $error("irq a fell");
  a_irq_set_cause: assert property ($rose(irqEdgeFlagA)
    && !$past(wrFlags) |-> lowAge_r < 6'h1e) else $error("irq a rose");
  a_reset_clears: assert property (disable iff (1'b0) !reset_n
    |=> sfrRdData == 8'h00 && !overflowFlagA && !overflowFlagB
    && !irqEdgeFlagA) else $error("reset left state");
endmodule : dtc_tc_assertions
bind dtc_timer_counter dtc_tc_assertions u_assert (.clk(clk),
  .reset_n(reset_n), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
  .sfrSel(sfrSel), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
  .vecAckOvfA(vecAckOvfA), .vecAckOvfB(vecAckOvfB),
  .vecAckIrqA(vecAckIrqA), .ext_irq_pin_a(ext_irq_pin_a),
  .overflowFlagA(overflowFlagA), .overflowFlagB(overflowFlagB),
  .irqEdgeFlagA(irqEdgeFlagA));
`default_nettype wire

//--- verif/dtc_pin_model.sv
// Model of the external count and interrupt sources
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  // Clock
  input  wire logic clk,
  // Pins, pulled high when idle
  output var logic  cntA,
  output var logic  cntB,
  output var logic  irqA,
  output var logic  irqB
);
  initial begin
    cntA = 1'b1;
    cntB = 1'b1;
    irqA = 1'b1;
    irqB = 1'b1;
  end
  // Fastest legal train: every level lasts one machine cycle
  task automatic count_edges(input int n);
    repeat (n) begin
      repeat (12) @(posedge clk);
      cntA <= 1'b0;
      cntB <= 1'b0;
      repeat (12) @(posedge clk);
      cntA <= 1'b1;
      cntB <= 1'b1;
    end
  endtask : count_edges
  task automatic set_irq(input logic lvlA, input logic lvlB);
    irqA <= lvlA;
    irqB <= lvlB;
  endtask : set_irq
endmodule : dtc_pin_model
`default_nettype wire

//--- verif/dual_timer_counter_mode0_tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_mode0_tb;
  logic       clk = 1'b0, reset_n = 1'b0, sfrWrEn = 1'b0, sfrRdEn = 1'b0;
  logic       ackOvfA = 1'b0, ackOvfB = 1'b0, ackIrqA = 1'b0, ackIrqB = 1'b0;
  logic       cntA, cntB, irqPinA, irqPinB, ovfA, ovfB, irqA, irqB;
  logic [7:0] sfrWrData = 8'h00, sfrRdData, rd;
  int         num_errors = 0, checks_done = 0, cycles = 0;
  dtc_pkg::dtc_sfr_t sfrSel = dtc_pkg::DTC_SEL_RUNFLAGS;
  dtc_pin_model u_pins (.clk(clk), .cntA(cntA), .cntB(cntB),
    .irqA(irqPinA), .irqB(irqPinB));
  dtc_timer_counter u_dut (.clk(clk), .reset_n(reset_n),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrSel(sfrSel),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .vecAckOvfA(ackOvfA),
    .vecAckOvfB(ackOvfB), .vecAckIrqA(ackIrqA), .vecAckIrqB(ackIrqB),
    .count_pin_a(cntA), .count_pin_b(cntB), .ext_irq_pin_a(irqPinA),
    .ext_irq_pin_b(irqPinB), .overflowFlagA(ovfA), .overflowFlagB(ovfB),
    .irqEdgeFlagA(irqA), .irqEdgeFlagB(irqB));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string w, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  // Selects: 0 run/flags, 1 mode, 2/3 low/high A, 4/5 low/high B
  task automatic wr(input int s, input logic [7:0] d);
    sfrWrEn <= 1'b1;
    sfrSel <= dtc_pkg::dtc_sfr_t'(s[2:0]);
    sfrWrData <= d;
    @(posedge clk);
    sfrWrEn <= 1'b0;
    // One idle edge keeps back-to-back writes from re-driving the strobe
    @(posedge clk);
  endtask : wr
  task automatic rd8(input int s);
    sfrRdEn <= 1'b1;
    sfrSel <= dtc_pkg::dtc_sfr_t'(s[2:0]);
    @(posedge clk);
    sfrRdEn <= 1'b0;
    @(posedge clk);
    rd = sfrRdData;
  endtask : rd8
  task automatic rdchk(input string w, input int s, input logic [7:0] e);
    rd8(s);
    chk(w, rd, e);
  endtask : rdchk
  task automatic waitf(ref logic f, input int lo, hi, input string w);
    int n;
    n = 0;
    while (f !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    chk(w, 8'(n >= lo && n < hi), 8'h01);
  endtask : waitf
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdchk("reset value", i, 8'h00);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_timer;
    logic [7:0] held;
    wr(1, 8'h00);
    rdchk("mode", 1, 8'h00);
    wr(2, 8'hfe);
    wr(3, 8'hff);
    wr(0, 8'h10);
    rdchk("run a", 0, 8'h10);
    waitf(ovfA, 11, 23, "ovf a wrap");
    wr(0, 8'h20);
    rd8(2);
    held = rd;
    chk("low a top", rd & 8'he0, 8'he0);
    rdchk("high a", 3, 8'h00);
    repeat (30) @(posedge clk);
    rdchk("stopped low a", 2, held);
    ackOvfA <= 1'b1;
    @(posedge clk);
    ackOvfA <= 1'b0;
    @(posedge clk);
    chk("ovf a ack", {7'h00, ovfA}, 8'h00);
    wr(0, 8'h10);
    rd8(2);
    chk("low a kept", rd & 8'he0, 8'he0);
    wr(0, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_counter;
    wr(1, 8'h44);
    wr(4, 8'h1d);
    wr(5, 8'hff);
    wr(0, 8'h50);
    u_pins.count_edges(5);
    repeat (36) @(posedge clk);
    chk("ovf b", {7'h00, ovfB}, 8'h01);
    wr(0, 8'h80);
    rdchk("low b", 4, 8'h02);
    rdchk("high b", 5, 8'h00);
    rdchk("low a count", 2, 8'he5);
    ackOvfB <= 1'b1;
    @(posedge clk);
    ackOvfB <= 1'b0;
    @(posedge clk);
    chk("ovf b ack", {7'h00, ovfB}, 8'h00);
    $display("test counter done");
  endtask : t_counter
  task automatic t_gate;
    wr(1, 8'h08);
    wr(2, 8'h00);
    u_pins.set_irq(1'b0, 1'b0);
    wr(0, 8'h10);
    repeat (48) @(posedge clk);
    rdchk("gated low a", 2, 8'h00);
    chk("level irq", {7'h00, irqA}, 8'h01);
    chk("level irq b", {7'h00, irqB}, 8'h01);
    u_pins.set_irq(1'b1, 1'b1);
    repeat (48) @(posedge clk);
    wr(0, 8'h00);
    rd8(2);
    chk("open low a", 8'(rd >= 8'h03 && rd <= 8'h05), 8'h01);
    for (int t = 0; t < 2; t++) begin
      ackIrqA <= 1'b1;
      ackIrqB <= 1'b1;
      // Pin back high first so the next drop is a fresh falling edge
      u_pins.set_irq(1'b1, 1'b1);
      @(posedge clk);
      ackIrqA <= 1'b0;
      ackIrqB <= 1'b0;
      repeat (36) @(posedge clk);
      chk("irq after ack", {7'h00, irqA}, 8'h00);
      chk("irq b after ack", {7'h00, irqB}, 8'h00);
      wr(0, 8'h01);
      u_pins.set_irq(1'b0, 1'b1);
      repeat (36) @(posedge clk);
      chk("edge irq", {7'h00, irqA}, 8'h01);
    end
    u_pins.set_irq(1'b1, 1'b1);
    $display("test gate and irq done");
  endtask : t_gate
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_counter();
    t_gate();
    end_of_test();
  end
endmodule : dual_timer_counter_mode0_tb
`default_nettype wire
